// ### verilog/iobsc_map.svh
// Register offsets, select word fields and vector constants of the I/O host
`ifndef IOBSC_MAP_SVH
`define IOBSC_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------------------------------
`define IOBSC_OFF_CMD 8'h00
`define IOBSC_OFF_SELW 8'h04
`define IOBSC_OFF_STAT 8'h08
`define IOBSC_OFF_AUTOEN 8'h0C
`define IOBSC_OFF_IRQRAW 8'h10
`define IOBSC_OFF_RELEASE 8'h14
`define IOBSC_OFF_VECTOR 8'h18
`define IOBSC_OFF_HREG0 8'h20

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define IOBSC_CMD_GO_SEL 0
`define IOBSC_CMD_GO_XFER 1
`define IOBSC_CMD_REG_LSB 2
`define IOBSC_CMD_REG_MSB 3
`define IOBSC_CMD_ACT_LSB 4
`define IOBSC_CMD_ACT_MSB 6
`define IOBSC_CMD_CHAN_LSB 8
`define IOBSC_CMD_CHAN_MSB 9

// ----------------------------------------------------------------
// Select word fields
// ----------------------------------------------------------------
`define IOBSC_SEL_STATUS_BIT 0
`define IOBSC_SEL_TYPE_LSB 1
`define IOBSC_SEL_TYPE_MSB 4
`define IOBSC_SEL_CNUM_LSB 5
`define IOBSC_SEL_CNUM_MSB 6
`define IOBSC_SEL_FMT_LSB 7
`define IOBSC_SEL_FMT_MSB 8
`define IOBSC_SEL_DEV_LSB 9
`define IOBSC_SEL_DEV_MSB 11
`define IOBSC_SEL_CHAN_LSB 12
`define IOBSC_SEL_CHAN_MSB 13
`define IOBSC_SEL_OP_LSB 14
`define IOBSC_SEL_OP_MSB 23

// ----------------------------------------------------------------
// Reset values and vector base (octal 70000)
// ----------------------------------------------------------------
`define IOBSC_RST_WORD 24'h00_0000
`define IOBSC_RST_AUTOEN 4'h0
`define IOBSC_VEC_BASE 15'h7000

`endif

// ### verilog/iobsc_pkg.sv
// Types of the I/O host select and transfer sequencer
package iobsc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DROP} iobsc_state_t;
    // Order gives the documented action codes 000 to 111
    typedef enum logic [2:0] {
        ACT_DISC, ACT_IN, ACT_OUT, ACT_INOUT,
        ACT_EOM, ACT_IN_EOM, ACT_OUT_EOM, ACT_STATUS
    } iobsc_action_t;
endpackage

// ### verilog/iobsc_commutator.sv
// Four-count commutator that scans and locks onto interrupt channels
`timescale 1ns/1ps
`default_nettype none
module iobsc_commutator (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] chan_irq,
    input wire logic [3:0] auto_en,
    input wire logic release_lock,
    input wire logic console_reset,
    output logic [1:0] chan,
    output logic locked
);
    logic [1:0] cnt_q;
    logic lock_q;
    wire hit_w = chan_irq[cnt_q] & auto_en[cnt_q];
    wire free_w = release_lock | console_reset;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 2'h0;
            lock_q <= 1'b0;
        end else if (free_w) begin
            lock_q <= 1'b0;
        end else if (lock_q) begin
            cnt_q <= cnt_q;
        end else if (hit_w) begin
            lock_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    assign chan = cnt_q;
    assign locked = lock_q;
endmodule
`default_nettype wire

// ### verilog/iobsc_host.sv
// I/O host: select and transfer sequencer, channels, vectoring, AHB regs
//
// Summary of operation
// - Select drives control lines plus the 24-bit select word outbound.
// - Host loads returned status into the host register named.
// - Status-only select returns status without starting the function.
// - Transfer names one host register that sends, receives or both.
// - Host decodes the transfer action field into its control lines.
// - Host provides four channels, each with interrupt and enable.
// - Each selected controller gets a channel no other controller uses.
// - Host drives the channel enable when a transfer begins.
// - Four-state commutator advances every clock, scanning one channel.
// - Pending and enabled interrupt stops the commutator on that channel.
// - After the instruction pair, force vector access at base plus channel.
// - Without fast memory the same four vectors live in main memory.
// - Commutator stays locked until software release or console reset.
// - Per-channel auto interrupt enable; raw interrupts always readable.
// - Host clock is held during a command until acknowledge arrives.
// - Select word: status, type, number, format, device, channel, ops.
// - Action codes: disconnect, in, out, both, end, in+end, out+end, status.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iobsc_map.svh"
module iobsc_host #(
    parameter int NREG = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [23:0] q_bus,
    output logic q_sel,
    output logic q_stat,
    output logic act_disc,
    output logic act_in,
    output logic act_out,
    output logic act_eom,
    input wire logic [23:0] r_bus,
    input wire logic command_done_ack,
    input wire logic [3:0] chan_irq,
    output logic [3:0] chan_enable,
    output logic clk_hold,
    input wire logic instr_pair_done,
    input wire logic fast_mem_present,
    input wire logic console_reset,
    output logic vec_req,
    output logic [14:0] vec_addr,
    output logic vec_main
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    iobsc_pkg::iobsc_state_t st_q;
    logic [23:0] selw_q;
    logic [23:0] hreg_q [0:NREG-1];
    logic [3:0] auto_en_q;
    logic [3:0] busy_chan_q;
    logic cmd_sel_q;
    logic [1:0] cmd_reg_q;
    logic [2:0] cmd_act_q;
    logic [1:0] cmd_chan_q;
    logic refused_q;
    logic [7:0] ap_addr_q;
    logic ap_write_q;
    logic pend_q;
    logic rel_q;
    logic vec_done_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [23:0] q_bus_q;
    logic q_sel_q;
    logic q_stat_q;
    logic act_disc_q;
    logic act_in_q;
    logic act_out_q;
    logic act_eom_q;
    logic [3:0] chan_en_q;
    logic clk_hold_q;
    logic vec_req_q;
    logic [14:0] vec_addr_q;
    logic vec_main_q;
    logic [1:0] comm_chan;
    logic comm_locked;

    // ----------------------------------------------------------------
    // Bus slave decode
    // ----------------------------------------------------------------
    wire ap_valid_w = hsel & htrans[1] & hready;
    wire wr_en_w = pend_q & ap_write_q;
    wire wr_cmd_w = wr_en_w & (ap_addr_q == `IOBSC_OFF_CMD);
    wire wr_selw_w = wr_en_w & (ap_addr_q == `IOBSC_OFF_SELW);
    wire wr_auto_w = wr_en_w & (ap_addr_q == `IOBSC_OFF_AUTOEN);
    wire wr_rel_w = wr_en_w & (ap_addr_q == `IOBSC_OFF_RELEASE) & hwdata[0];
    wire hreg_hit_w = (ap_addr_q[7:4] == 4'(`IOBSC_OFF_HREG0 >> 4))
                      & (int'(ap_addr_q[3:2]) < NREG);
    wire [1:0] hreg_idx_w = ap_addr_q[3:2];

    // ----------------------------------------------------------------
    // Command launch and action decode
    // ----------------------------------------------------------------
    wire go_sel_w = wr_cmd_w & hwdata[`IOBSC_CMD_GO_SEL];
    wire go_xfer_w = wr_cmd_w & ~hwdata[`IOBSC_CMD_GO_SEL]
                     & hwdata[`IOBSC_CMD_GO_XFER];
    wire [2:0] new_act_w = hwdata[`IOBSC_CMD_ACT_MSB:`IOBSC_CMD_ACT_LSB];
    wire [1:0] new_chan_w = hwdata[`IOBSC_CMD_CHAN_MSB:`IOBSC_CMD_CHAN_LSB];
    wire sel_stat_only_w = selw_q[`IOBSC_SEL_STATUS_BIT];
    wire [1:0] sel_chan_w = selw_q[`IOBSC_SEL_CHAN_MSB:`IOBSC_SEL_CHAN_LSB];
    // A data select onto a channel already owned would share it
    wire sel_clash_w = ~sel_stat_only_w & busy_chan_q[sel_chan_w];
    wire start_w = (st_q == iobsc_pkg::ST_IDLE)
                   & ((go_sel_w & ~sel_clash_w) | go_xfer_w);
    wire refuse_w = (go_sel_w | go_xfer_w) & ~start_w;
    wire dec_disc_w = new_act_w == iobsc_pkg::ACT_DISC;
    wire dec_stat_w = new_act_w == iobsc_pkg::ACT_STATUS;
    wire dec_in_w = new_act_w[0] & ~dec_stat_w;
    wire dec_out_w = new_act_w[1] & ~dec_stat_w;
    wire dec_eom_w = new_act_w[2] & ~dec_stat_w;
    wire ack_w = (st_q == iobsc_pkg::ST_WAIT) & command_done_ack;
    wire load_w = ack_w & (cmd_sel_q | cmd_act_q[0]
                  | cmd_act_q == iobsc_pkg::ACT_STATUS);
    wire scan_hit_w = chan_irq[comm_chan] & auto_en_q[comm_chan];

    // ----------------------------------------------------------------
    // Register read mux
    // ----------------------------------------------------------------
    wire [31:0] stat_w = {16'h0000, 3'h0, ~vec_done_q & comm_locked,
                          busy_chan_q, 3'h0, comm_locked, comm_chan,
                          refused_q, st_q != iobsc_pkg::ST_IDLE};
    wire [31:0] cmd_rd_w = {22'h00_0000, cmd_chan_q, 1'b0, cmd_act_q,
                            cmd_reg_q, 2'h0};
    wire [31:0] rd_mux_w =
        (ap_addr_q == `IOBSC_OFF_CMD) ? cmd_rd_w :
        (ap_addr_q == `IOBSC_OFF_SELW) ? {8'h00, selw_q} :
        (ap_addr_q == `IOBSC_OFF_STAT) ? stat_w :
        (ap_addr_q == `IOBSC_OFF_AUTOEN) ? {28'h000_0000, auto_en_q} :
        (ap_addr_q == `IOBSC_OFF_IRQRAW) ? {28'h000_0000, chan_irq} :
        (ap_addr_q == `IOBSC_OFF_VECTOR) ? {16'h0000, vec_main_q, vec_addr_q} :
        hreg_hit_w ? {8'h00, hreg_q[hreg_idx_w]} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // AHB-Lite slave, one wait state per transfer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
            ap_addr_q <= 8'h00;
            ap_write_q <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            hreadyout_q <= 1'b1;
            hrdata_q <= ap_write_q ? 32'h0000_0000 : rd_mux_w;
        end else if (ap_valid_w) begin
            pend_q <= 1'b1;
            hreadyout_q <= 1'b0;
            ap_addr_q <= haddr[7:0];
            ap_write_q <= hwrite;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            selw_q <= `IOBSC_RST_WORD;
            auto_en_q <= `IOBSC_RST_AUTOEN;
            rel_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (wr_selw_w) begin
                selw_q <= hwdata[23:0];
            end
            if (wr_auto_w) begin
                auto_en_q <= hwdata[3:0];
            end
            rel_q <= wr_rel_w;
            if (refuse_w) begin
                refused_q <= 1'b1;
            end else if (start_w) begin
                refused_q <= 1'b0;
            end
        end
    end

    // Host registers; a link load wins over a software write
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1) begin : g_hreg
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    hreg_q[gi] <= `IOBSC_RST_WORD;
                end else if (load_w && cmd_reg_q == 2'(gi)) begin
                    hreg_q[gi] <= r_bus;
                end else if (wr_en_w && hreg_hit_w
                             && hreg_idx_w == 2'(gi)) begin
                    hreg_q[gi] <= hwdata[23:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= iobsc_pkg::ST_IDLE;
            cmd_sel_q <= 1'b0;
            cmd_reg_q <= 2'h0;
            cmd_act_q <= 3'h0;
            cmd_chan_q <= 2'h0;
            busy_chan_q <= 4'h0;
            q_bus_q <= `IOBSC_RST_WORD;
            q_sel_q <= 1'b0;
            q_stat_q <= 1'b0;
            act_disc_q <= 1'b0;
            act_in_q <= 1'b0;
            act_out_q <= 1'b0;
            act_eom_q <= 1'b0;
            chan_en_q <= 4'h0;
            clk_hold_q <= 1'b0;
        end else begin
            case (st_q)
                iobsc_pkg::ST_IDLE: begin
                    if (start_w) begin
                        st_q <= iobsc_pkg::ST_WAIT;
                        clk_hold_q <= 1'b1;
                        cmd_sel_q <= go_sel_w;
                        cmd_reg_q <= hwdata[`IOBSC_CMD_REG_MSB:
                                            `IOBSC_CMD_REG_LSB];
                        cmd_act_q <= new_act_w;
                        cmd_chan_q <= go_sel_w ? sel_chan_w : new_chan_w;
                        if (go_sel_w) begin
                            q_bus_q <= selw_q;
                            q_sel_q <= 1'b1;
                            q_stat_q <= 1'b1;
                        end else begin
                            q_bus_q <= hreg_q[hwdata[`IOBSC_CMD_REG_MSB:
                                                     `IOBSC_CMD_REG_LSB]];
                            q_stat_q <= dec_stat_w;
                            act_disc_q <= dec_disc_w;
                            act_in_q <= dec_in_w;
                            act_out_q <= dec_out_w;
                            act_eom_q <= dec_eom_w;
                            chan_en_q <= 4'h1 << new_chan_w;
                        end
                    end
                end
                iobsc_pkg::ST_WAIT: begin
                    if (command_done_ack) begin
                        st_q <= iobsc_pkg::ST_DROP;
                        clk_hold_q <= 1'b0;
                        q_bus_q <= `IOBSC_RST_WORD;
                        q_sel_q <= 1'b0;
                        q_stat_q <= 1'b0;
                        act_disc_q <= 1'b0;
                        act_in_q <= 1'b0;
                        act_out_q <= 1'b0;
                        act_eom_q <= 1'b0;
                        chan_en_q <= 4'h0;
                        if (cmd_sel_q && !q_bus_q[`IOBSC_SEL_STATUS_BIT]) begin
                            busy_chan_q[cmd_chan_q] <= 1'b1;
                        end else if (!cmd_sel_q && act_disc_q) begin
                            busy_chan_q[cmd_chan_q] <= 1'b0;
                        end
                    end
                end
                iobsc_pkg::ST_DROP: begin
                    if (!command_done_ack) begin
                        st_q <= iobsc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= iobsc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Commutator and forced vector
    // ----------------------------------------------------------------
    iobsc_commutator u_comm (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .chan_irq(chan_irq),
        .auto_en(auto_en_q),
        .release_lock(rel_q),
        .console_reset(console_reset),
        .chan(comm_chan),
        .locked(comm_locked)
    );

    // One vector per lock; a new lock is needed for the next one
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            vec_done_q <= 1'b0;
            vec_req_q <= 1'b0;
            vec_addr_q <= `IOBSC_VEC_BASE;
            vec_main_q <= 1'b0;
        end else begin
            vec_req_q <= comm_locked & ~vec_done_q & instr_pair_done;
            if (!comm_locked) begin
                vec_done_q <= 1'b0;
            end else if (instr_pair_done && !vec_done_q) begin
                vec_done_q <= 1'b1;
                vec_addr_q <= `IOBSC_VEC_BASE
                              + {13'h0000, comm_chan};
                vec_main_q <= ~fast_mem_present;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign q_bus = q_bus_q;
    assign q_sel = q_sel_q;
    assign q_stat = q_stat_q;
    assign act_disc = act_disc_q;
    assign act_in = act_in_q;
    assign act_out = act_out_q;
    assign act_eom = act_eom_q;
    assign chan_enable = chan_en_q;
    assign clk_hold = clk_hold_q;
    assign vec_req = vec_req_q;
    assign vec_addr = vec_addr_q;
    assign vec_main = vec_main_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_sel_word;
        @(posedge clk_sys) disable iff (sys_rst)
        (st_q == iobsc_pkg::ST_IDLE && start_w && go_sel_w)
        |=> q_sel && q_bus == $past(selw_q);
    endproperty
    a_sel_word: assert property (p_sel_word)
        else $error("select word not driven");

    property p_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (st_q == iobsc_pkg::ST_WAIT && !command_done_ack)
        |=> clk_hold throughout (st_q == iobsc_pkg::ST_WAIT) [*1];
    endproperty
    a_hold: assert property (p_hold)
        else $error("clock hold dropped before ack");

    property p_release;
        @(posedge clk_sys) disable iff (sys_rst)
        ack_w |=> !clk_hold && !q_sel && chan_enable == 4'h0;
    endproperty
    a_release: assert property (p_release)
        else $error("command not ended on ack");

    property p_status_load;
        @(posedge clk_sys) disable iff (sys_rst)
        (ack_w && cmd_sel_q) |=> hreg_q[cmd_reg_q] == $past(r_bus);
    endproperty
    a_status_load: assert property (p_status_load)
        else $error("status word not loaded");

    property p_action;
        @(posedge clk_sys) disable iff (sys_rst)
        (start_w && go_xfer_w && new_act_w == iobsc_pkg::ACT_IN)
        |=> act_in && !act_out && !act_eom && !q_stat ##1 !act_out;
    endproperty
    a_action: assert property (p_action)
        else $error("input action decoded wrong");

    property p_enable;
        @(posedge clk_sys) disable iff (sys_rst)
        (start_w && go_xfer_w)
        |=> chan_enable == (4'h1 << $past(new_chan_w));
    endproperty
    a_enable: assert property (p_enable)
        else $error("channel enable wrong");

    property p_scan;
        @(posedge clk_sys) disable iff (sys_rst)
        (!comm_locked && !scan_hit_w && !rel_q && !console_reset)
        |=> comm_chan == $past(comm_chan) + 2'h1;
    endproperty
    a_scan: assert property (p_scan)
        else $error("commutator did not advance");

    property p_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        (scan_hit_w && !rel_q && !console_reset)
        |=> comm_locked && comm_chan == $past(comm_chan);
    endproperty
    a_lock: assert property (p_lock)
        else $error("commutator did not lock");

    property p_stay;
        @(posedge clk_sys) disable iff (sys_rst)
        (comm_locked && !rel_q && !console_reset) |=> comm_locked;
    endproperty
    a_stay: assert property (p_stay)
        else $error("lock lost without release");

    property p_vector;
        @(posedge clk_sys) disable iff (sys_rst)
        vec_req |-> comm_locked || $past(rel_q) || $past(console_reset)
                    ##0 vec_addr == `IOBSC_VEC_BASE
                    + {13'h0000, $past(comm_chan)};
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector address wrong");
endmodule
`default_nettype wire

// ### verification/iobsc_ctrl_model.sv
// Behavioural peripheral controller on the outbound and inbound buses
`timescale 1ns/1ps
`default_nettype none
module iobsc_ctrl_model #(
    parameter logic [8:0] OWN_ID = 9'h0a5
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [23:0] q_bus,
    input wire logic q_sel,
    input wire logic xfer_req,
    input wire logic [3:0] dly,
    output logic [23:0] r_bus,
    output logic command_done_ack
);
    logic [3:0] cnt_q;
    logic req;
    // Select answered on full identity match
    assign req = xfer_req
        | (q_sel & {q_bus[11:9], q_bus[6:5], q_bus[4:1]} == OWN_ID);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 4'h0;
            command_done_ack <= 1'b0;
            r_bus <= 24'h00_0000;
        end else if (!req) begin
            cnt_q <= 4'h0;
            command_done_ack <= 1'b0;
            r_bus <= ~r_bus; // Released bus never keeps a stale word
        end else if (cnt_q >= dly) begin
            command_done_ack <= 1'b1;
            r_bus <= q_bus ^ 24'h5a_5a5a;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            r_bus <= ~r_bus;
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the I/O host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic instr_pair_done = 1'b0, fast_mem_present = 1'b0;
    logic console_reset = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0] chan_irq = 4'h0, dly = 4'h0, chan_enable;
    logic [23:0] q_bus, r_bus;
    logic hreadyout, hresp, q_sel, q_stat, act_disc, act_in, act_out;
    logic act_eom, command_done_ack, clk_hold, vec_req, vec_main;
    logic [14:0] vec_addr;
    int bad_count = 0, compares = 0;
    localparam logic [23:0] SW = 24'h5c_244a, SO = 24'h5c_244b;
    always #12.5 clk_sys = ~clk_sys;
    iobsc_host uut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
        .hresp, .q_bus, .q_sel, .q_stat, .act_disc, .act_in, .act_out,
        .act_eom, .r_bus, .command_done_ack, .chan_irq, .chan_enable,
        .clk_hold, .instr_pair_done, .fast_mem_present, .console_reset,
        .vec_req, .vec_addr, .vec_main);
    iobsc_ctrl_model ctl (.clk_sys, .sys_rst, .q_bus, .q_sel, .dly, .r_bus,
        .command_done_ack,
        .xfer_req(~q_sel & (q_stat | act_disc | act_in | act_out | act_eom)));
    // ------
    // Helpers
    // ------
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 40) begin
            bad_count++;
            end_of_test;
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 40);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 40);
        rd = hrdata;
        hang(n);
    endtask
    task automatic wait_idle(output int n);
        n = 0;
        while (clk_hold === 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        hang(n);
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_reset;
        ahb(1'b0, 8'h08, 32'h0);
        // The commutator runs free after reset, so its count is masked
        chk({rd[31:4], rd[1:0]} === 30'h0 && q_sel === 1'b0
            && hresp === 1'b0, "reset");
        ahb(1'b0, 8'h3c, 32'h0);
        chk(rd === 32'h0, "unmapped");
        $display("t_reset finished");
    endtask
    task automatic t_select;
        int n;
        dly <= 4'h7;
        ahb(1'b1, 8'h04, {8'h00, SW});
        ahb(1'b1, 8'h00, 32'h0000_0005);
        @(negedge clk_sys);
        chk(q_sel & q_stat & clk_hold, "select lines");
        chk(q_bus === SW, "select word");
        wait_idle(n);
        chk(n >= 7, "stall too short");
        ahb(1'b0, 8'h24, 32'h0);
        chk(rd === {8'h00, SW ^ 24'h5a_5a5a}, "status load");
        ahb(1'b1, 8'h00, 32'h0000_0005);
        @(negedge clk_sys);
        chk(q_sel === 1'b0, "channel reuse");
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd[11:8] === 4'h4 && rd[1] === 1'b1, "refuse flag");
        // Status-only select onto the owned channel is allowed
        ahb(1'b1, 8'h04, {8'h00, SO});
        ahb(1'b1, 8'h00, 32'h0000_0009);
        wait_idle(n);
        ahb(1'b0, 8'h28, 32'h0);
        chk(rd === {8'h00, SO ^ 24'h5a_5a5a}, "stat only");
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd[11:8] === 4'h4 && rd[1] === 1'b0, "no claim");
        $display("t_select finished");
    endtask
    task automatic t_xfer;
        logic [2:0] a;
        logic s;
        logic [23:0] v;
        int n;
        dly <= 4'h0;
        for (int k = 1; k <= 8; k++) begin
            a = k[2:0];
            s = (a == 3'h7);
            v = {16'h1234, k[7:0]};
            ahb(1'b1, 8'h20, {8'h00, v});
            ahb(1'b1, 8'h00, {22'h0, 2'h2, 1'b0, a, 2'h0, 2'h2});
            @(negedge clk_sys);
            chk({act_disc, act_in, act_out, act_eom, q_stat} === {a == 3'h0,
                a[0] & ~s, a[1] & ~s, a[2] & ~s, s}, "action");
            chk(chan_enable === 4'h4, "enable");
            chk(q_bus === v && q_sel === 1'b0, "data");
            wait_idle(n);
            ahb(1'b0, 8'h20, 32'h0);
            chk(rd[23:0] === ((a[0] | s) ? v ^ 24'h5a_5a5a : v), "in");
        end
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd[10] === 1'b0 && rd[1] === 1'b0, "disconnect");
        $display("t_xfer finished");
    endtask
    task automatic t_comm(input logic [1:0] c, input logic fm);
        int n;
        fast_mem_present <= fm;
        // Mask first, so a left-over enable cannot lock early
        ahb(1'b1, 8'h0c, 32'h0);
        chan_irq <= 4'h1 << c;
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd[3:0] === 4'h1 << c, "raw irq");
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd[4] === 1'b0, "masked lock");
        ahb(1'b1, 8'h0c, 32'h0000_000f);
        repeat (5) @(posedge clk_sys); // Four-count scan covers every channel
        chan_irq <= 4'h0;
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd[4] === 1'b1 && rd[3:2] === c, "lock");
        instr_pair_done <= 1'b1;
        @(posedge clk_sys);
        instr_pair_done <= 1'b0;
        n = 0;
        while (vec_req !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        hang(n);
        chk(vec_addr === 15'h7000 + 15'(c), "vector");
        chk(vec_main === ~fm, "memory");
        if (fm) begin
            @(posedge clk_sys);
            console_reset <= 1'b1;
            @(posedge clk_sys);
            console_reset <= 1'b0;
        end else begin
            ahb(1'b1, 8'h14, 32'h0000_0001);
        end
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd[4] === 1'b0, "unlock");
        $display("t_comm finished");
    endtask
    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_select;
        t_xfer;
        t_comm(2'h1, 1'b0);
        t_comm(2'h3, 1'b1);
        end_of_test;
    end
    initial begin
        #2_000_000;
        bad_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
